// File: rtcd_clock.sv
// BCD clock/calendar with an I2C slave register port
//
// Summary of operation
// R1: Answer only when the seven-bit address after START matches our own.
// R2: After a write address byte, the next byte loads the word pointer.
// R3: Repeated START with read direction transmits the byte at the pointer.
// R4: On reads, pointer advances only on master acknowledge, then sends next.
// R5: Sequential reads continue until the master sends STOP.
// R6: A read without a pointer write starts from the last pointer value.
// R7: Each written data byte is stored, pointer advances on its ack clock.
// R8: Acknowledge slave address, word address and every received data byte.
// R9: Timekeeping registers hold BCD for both setting and reading.
// R10: Seconds and minutes 00-59, hours 00-23, tens high, units low.
// R11: Hours bit 7 enables century toggle; bit 6 toggles at rollover.
// R12: Weekday in bits 2:0 counts 01 to 07.
// R13: Date 01-31, month 01-12, year 00-99 with calendar rollover.
// R14: Seconds bit 7 halts oscillator and timekeeping; 0 restarts it.
// R15: Time base is the 32.768 kHz oscillator.
// R16: Clock registers read singly or in blocks; control reachable alone.
// R17: Reads freeze readable registers up to 250 ms; time keeps counting.
// R18: Output pin low when control bit 7 is 0, released when 1.
// R19: Minutes bit 7 fail flag sets whenever the oscillator stops.
// R20: Fail flag stays 1 until software writes 0.
// R21: Software clears the fail flag only after four seconds of running; the code clears it on any write of 0 while the oscillator runs.
// R22: Reset sets output bit and fail flag, clears the halt bit.
// R23: Master writes control bit 6 as 0; bits 5:0 are don't care.
// R24: Pointer wraps from address 7 to 0.
// R25: Seconds advance once per divided second and carry upward.
`timescale 1ns/10ps
`include "rtcd_defs.svh"
module rtcd_clock import rtcd_pkg::*; #(
   parameter int FREEZE_CYC  = `RTCD_FREEZE_MS * `RTCD_CLK_MHZ * 1000,
   parameter int OSC_TMO_CYC = `RTCD_OSC_TMO_US * `RTCD_CLK_MHZ,
   parameter int OSC_DIV     = `RTCD_OSC_DIV
) (
   input  wire logic CLK,
   input  wire logic RST_B,
   input  wire logic SCL_IN,
   input  wire logic SDA_IN,
   output logic      SDA_OUT,
   output logic      SDA_OE,
   input  wire logic OSC_IN,
   output logic      OSC_EN,
   output logic      OUT_OUT,
   output logic      OUT_OE
);
   if (OSC_DIV < 2 || FREEZE_CYC < 1 || OSC_TMO_CYC < 2) begin : g_bad
      $error("rtcd_clock: divider or timing parameter too small");
   end

   // Pin synchronisers; third stage only feeds edge detection
   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2, sda_s3;
   logic osc_s1, osc_s2, osc_s3;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
         {osc_s1, osc_s2, osc_s3} <= 3'h0;
      end else begin
         {scl_s1, scl_s2, scl_s3} <= {SCL_IN, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {SDA_IN, sda_s1, sda_s2};
         {osc_s1, osc_s2, osc_s3} <= {OSC_IN, osc_s1, osc_s2};
      end
   end
   wire logic scl_rise = scl_s2 & ~scl_s3;
   wire logic scl_fall = ~scl_s2 & scl_s3;
   wire logic start_c  = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   wire logic stop_c   = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   wire logic osc_edge = osc_s2 & ~osc_s3;

   // Register state
   logic [7:0]  tm [7];
   logic [7:0]  sh [7];
   logic        halt, fail, century_toggle_enable, century_flag, out_lvl;
   logic [2:0]  ptr;
   logic        frozen;
   logic [31:0] frz_cnt, div_cnt, tmo_cnt;
   logic        osc_dead;

   // I2C slave engine state
   rtcd_state_t state, next_state;
   rtcd_phase_t phase, next_phase;
   logic [3:0]  bitcnt, next_bitcnt;
   logic [7:0]  shreg, next_shreg;
   logic        rw, next_rw, next_drive;
   logic [2:0]  next_ptr;
   logic        wr_en, read_go;

   wire logic byte_done = (state == S_RX) && scl_fall && (bitcnt == 4'h8);
   wire logic addr_hit  = (shreg[7:1] == `RTCD_SLV_ADDR);
   wire logic [2:0] ptr_inc = 3'(ptr + 3'h1);                    // R24

   // Readback mux: frozen shadow for time fields, live flags
   wire logic [7:0] rd_byte =
      (ptr == `RTCD_REG_SEC)  ? {halt, sh[0][6:0]} :
      (ptr == `RTCD_REG_MIN)  ? {fail, sh[1][6:0]} :
      (ptr == `RTCD_REG_HOUR) ?
         {century_toggle_enable, century_flag, sh[2][5:0]} :
      (ptr == `RTCD_REG_CTRL) ? {out_lvl, 7'h00} :              // R16
                                sh[ptr];

   always_comb begin
      next_state  = state;
      next_phase  = phase;
      next_bitcnt = bitcnt;
      next_shreg  = shreg;
      next_rw     = rw;
      next_drive  = SDA_OE;
      next_ptr    = ptr;
      wr_en       = 1'b0;
      read_go     = 1'b0;
      if (start_c) begin
         next_state  = S_RX;                                      // R1
         next_phase  = PH_ADDR;
         next_bitcnt = 4'h0;
         next_drive  = 1'b0;
      end else if (stop_c) begin
         next_state = S_IDLE;                                     // R5
         next_drive = 1'b0;
      end else begin
         case (state)
            S_RX: begin
               if (scl_rise) begin
                  next_shreg  = {shreg[6:0], sda_s2};
                  next_bitcnt = 4'(bitcnt + 4'h1);
               end else if (byte_done) begin
                  next_drive = 1'b1;                              // R8
                  next_state = S_ACK;
                  case (phase)
                     PH_ADDR: begin
                        next_rw = shreg[0];
                        read_go = shreg[0] & addr_hit;
                        if (!addr_hit) begin
                           next_drive = 1'b0;                     // R1
                           next_state = S_IDLE;
                        end
                     end
                     PH_PTR:  next_ptr = shreg[2:0];              // R2
                     default: wr_en = 1'b1;                       // R7
                  endcase
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  next_drive  = 1'b0;
                  next_bitcnt = 4'h0;
                  next_state  = S_RX;
                  case (phase)
                     PH_ADDR: begin
                        next_phase = PH_PTR;
                        if (rw) begin
                           // Reads start at the held pointer
                           next_state  = S_TX;                    // R3 R6
                           next_drive  = ~rd_byte[7];
                           next_shreg  = {rd_byte[6:0], 1'b0};
                           next_bitcnt = 4'h1;
                        end
                     end
                     PH_PTR:  next_phase = PH_DATA;
                     default: next_ptr = ptr_inc;                 // R7
                  endcase
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  if (bitcnt == 4'h8) begin
                     next_drive = 1'b0;
                     next_state = S_MACK;
                  end else begin
                     next_drive  = ~shreg[7];
                     next_shreg  = {shreg[6:0], 1'b0};
                     next_bitcnt = 4'(bitcnt + 4'h1);
                  end
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  if (sda_s2) begin
                     next_state = S_IDLE;                         // R5
                  end else begin
                     next_ptr   = ptr_inc;                        // R4
                     next_state = S_TXLD;
                  end
               end
            end
            S_TXLD: begin
               if (scl_fall) begin
                  next_state  = S_TX;                             // R4
                  next_drive  = ~rd_byte[7];
                  next_shreg  = {rd_byte[6:0], 1'b0};
                  next_bitcnt = 4'h1;
               end
            end
            default: next_state = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state  <= S_IDLE;
         phase  <= PH_ADDR;
         bitcnt <= 4'h0;
         shreg  <= 8'h00;
         rw     <= 1'b0;
         SDA_OE <= 1'b0;
         ptr    <= 3'h0;
      end else begin
         state  <= next_state;
         phase  <= next_phase;
         bitcnt <= next_bitcnt;
         shreg  <= next_shreg;
         rw     <= next_rw;
         SDA_OE <= next_drive;
         ptr    <= next_ptr;
      end
   end

   // Time base: divide the oscillator edges down to one tick per second
   wire logic sec_tick = osc_edge && !halt &&
                         (div_cnt == 32'(OSC_DIV - 1));          // R15 R25
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         div_cnt <= 32'h0;
      end else if (halt) begin
         div_cnt <= 32'h0;                                        // R14
      end else if (osc_edge) begin
         div_cnt <= sec_tick ? 32'h0 : 32'(div_cnt + 32'h1);
      end
   end

   // Stop detection: no oscillator edge within the timeout
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         tmo_cnt  <= 32'h0;
         osc_dead <= 1'b0;
      end else begin
         tmo_cnt  <= osc_edge ? 32'h0 :
                     osc_dead ? tmo_cnt : 32'(tmo_cnt + 32'h1);
         osc_dead <= !osc_edge && (tmo_cnt >= 32'(OSC_TMO_CYC - 1));
      end
   end

   // Calendar carry chain
   logic [7:0] cur [7];
   logic [7:0] lo_v [7];
   logic [7:0] hi_v [7];
   logic [7:0] nxt [7];
   logic [6:0] wrap, inc;
   assign cur[0] = tm[0] & `RTCD_MASK_SEC;
   assign cur[1] = tm[1] & `RTCD_MASK_MIN;
   assign cur[2] = tm[2] & `RTCD_MASK_HOUR;
   assign cur[3] = tm[3] & `RTCD_MASK_WDAY;
   assign cur[4] = tm[4] & `RTCD_MASK_DATE;
   assign cur[5] = tm[5] & `RTCD_MASK_MONTH;
   assign cur[6] = tm[6] & `RTCD_MASK_YEAR;
   // Year 00 counts as leap; the century flag carries no leap meaning
   wire logic leap = tm[6][4] ? (tm[6][3:0] == 4'h2 || tm[6][3:0] == 4'h6)
                   : (tm[6][3:0] == 4'h0 || tm[6][3:0] == 4'h4 ||
                      tm[6][3:0] == 4'h8);
   wire logic short_m = (cur[5] == 8'h04) || (cur[5] == 8'h06) ||
                        (cur[5] == 8'h09) || (cur[5] == 8'h11);
   wire logic [7:0] dim = (cur[5] == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                          short_m ? 8'h30 : 8'h31;               // R13
   assign lo_v[0] = 8'h00;  assign hi_v[0] = 8'h59;               // R10
   assign lo_v[1] = 8'h00;  assign hi_v[1] = 8'h59;
   assign lo_v[2] = 8'h00;  assign hi_v[2] = 8'h23;
   assign lo_v[3] = 8'h01;  assign hi_v[3] = 8'h07;               // R12
   assign lo_v[4] = 8'h01;  assign hi_v[4] = dim;
   assign lo_v[5] = 8'h01;  assign hi_v[5] = 8'h12;
   assign lo_v[6] = 8'h00;  assign hi_v[6] = 8'h99;
   assign inc[0] = sec_tick;                                      // R25
   assign inc[1] = inc[0] & wrap[0];
   assign inc[2] = inc[1] & wrap[1];
   assign inc[3] = inc[2] & wrap[2];
   assign inc[4] = inc[2] & wrap[2];
   assign inc[5] = inc[4] & wrap[4];
   assign inc[6] = inc[5] & wrap[5];
   wire logic cent_roll = inc[6] & wrap[6];

   for (genvar i = 0; i < 7; i++) begin : g_field
      rtcd_bcd_step u_step (
         .val  (cur[i]),
         .lo   (lo_v[i]),
         .hi   (hi_v[i]),
         .nxt  (nxt[i]),
         .wrap (wrap[i])
      );
      // Software write beats a same-cycle count on that field
      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            tm[i] <= (i >= 3 && i <= 5) ? `RTCD_RST_DAY : `RTCD_RST_TIME;
         end else if (wr_en && ptr == 3'(i)) begin
            tm[i] <= shreg;                                       // R9
         end else if (inc[i]) begin
            tm[i] <= nxt[i];
         end
      end
      // Readable copy holds still during a read not started at control, until STOP, START or timeout
      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            sh[i] <= 8'h00;
         end else if (!frozen) begin
            sh[i] <= cur[i];                                      // R17
         end
      end
   end

   // Flags and control bits
   wire logic wr_sec  = wr_en && ptr == `RTCD_REG_SEC;
   wire logic wr_min  = wr_en && ptr == `RTCD_REG_MIN;
   wire logic wr_hour = wr_en && ptr == `RTCD_REG_HOUR;
   wire logic wr_ctrl = wr_en && ptr == `RTCD_REG_CTRL;
   wire logic osc_stop = halt || osc_dead;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         halt    <= 1'b0;                                         // R22
         fail    <= 1'b1;
         out_lvl <= 1'b1;
         century_toggle_enable <= 1'b0;
         century_flag          <= 1'b0;
      end else begin
         if (wr_sec) halt <= shreg[`RTCD_BIT_HALT];               // R14
         // Stop event beats a software clear
         if (osc_stop) fail <= 1'b1;                              // R19
         else if (wr_min) fail <= shreg[`RTCD_BIT_FAIL];          // R20
         if (wr_hour) begin
            century_toggle_enable <= shreg[`RTCD_BIT_CENT_EN];
            century_flag          <= shreg[`RTCD_BIT_CENT];
         end else if (cent_roll && century_toggle_enable) begin
            century_flag <= ~century_flag;                        // R11
         end
         if (wr_ctrl) out_lvl <= shreg[`RTCD_BIT_OUT];            // R18
      end
   end

   // Freeze window: from a matched read not started at control to STOP, START or timeout
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         frozen  <= 1'b0;
         frz_cnt <= 32'h0;
      end else if (start_c || stop_c) begin
         frozen  <= 1'b0;
         frz_cnt <= 32'h0;
      end else if (read_go && ptr != `RTCD_REG_CTRL) begin
         frozen  <= 1'b1;                                         // R17
         frz_cnt <= 32'h0;
      end else if (frozen) begin
         frozen  <= (frz_cnt < 32'(FREEZE_CYC - 1));
         frz_cnt <= 32'(frz_cnt + 32'h1);
      end
   end

   // Pin drivers, all registered
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         SDA_OUT <= 1'b0;
         OUT_OUT <= 1'b0;
         OUT_OE  <= 1'b0;
         OSC_EN  <= 1'b1;
      end else begin
         SDA_OUT <= 1'b0;
         OUT_OUT <= 1'b0;
         OUT_OE  <= ~out_lvl;                                     // R18
         OSC_EN  <= ~halt;                                        // R14
      end
   end

   // Checks
   sequence seq_byte_in;
      byte_done && phase != PH_ADDR;
   endsequence
   sequence seq_mack_ok;
      state == S_MACK && scl_rise && !sda_s2 && !start_c && !stop_c;
   endsequence
   a_start_to_rx: assert property (@(posedge CLK) disable iff (!RST_B) // R1
      start_c |=> state == S_RX && bitcnt == 4'h0 && !SDA_OE)
      else $error("START did not reset receiver");
   a_miss_ignored: assert property (@(posedge CLK) disable iff (!RST_B) // R1
      byte_done && phase == PH_ADDR && !addr_hit && !start_c && !stop_c
      |=> state == S_IDLE && !SDA_OE [*2])
      else $error("foreign address not ignored");
   a_ptr_loaded: assert property (@(posedge CLK) disable iff (!RST_B) // R2
      byte_done && phase == PH_PTR && !start_c && !stop_c
      |=> ptr == $past(shreg[2:0]))
      else $error("pointer byte not loaded");
   a_ack_received: assert property (@(posedge CLK) disable iff (!RST_B) // R8
      seq_byte_in and (!start_c && !stop_c) |=> SDA_OE && state == S_ACK)
      else $error("received byte not acknowledged");
   a_read_advance: assert property (@(posedge CLK) disable iff (!RST_B) // R4
      seq_mack_ok |=> ptr == 3'($past(ptr) + 3'h1) && state == S_TXLD)
      else $error("read pointer did not advance");
   a_nack_ends: assert property (@(posedge CLK) disable iff (!RST_B) // R5
      state == S_MACK && scl_rise && sda_s2 |=> state == S_IDLE)
      else $error("read continued after no-acknowledge");
   a_write_advance: assert property (@(posedge CLK) disable iff (!RST_B) // R7
      state == S_ACK && phase == PH_DATA && scl_fall && !start_c && !stop_c
      |=> ptr == 3'($past(ptr) + 3'h1))
      else $error("write pointer did not advance");
   a_fail_sticky: assert property (@(posedge CLK) disable iff (!RST_B) // R19
      halt |=> fail [*2])
      else $error("fail flag not held while halted");
   a_freeze_hold: assert property (@(posedge CLK) disable iff (!RST_B) // R17
      frozen && $past(frozen) |-> sh[0] == $past(sh[0]))
      else $error("seconds copy changed during read");
   a_century_keep: assert property (@(posedge CLK) disable iff (!RST_B) // R11
      cent_roll && !century_toggle_enable && !wr_hour
      |=> century_flag == $past(century_flag))
      else $error("century flag toggled while disabled");
   a_out_follow: assert property (@(posedge CLK) disable iff (!RST_B) // R18
      ##1 OUT_OE == !$past(out_lvl))
      else $error("output pin does not follow control bit");
endmodule : rtcd_clock

// File: rtcd_defs.svh
// Register offsets, field positions, reset values and timing for the clock
`ifndef RTCD_DEFS_SVH
`define RTCD_DEFS_SVH
`define RTCD_SLV_ADDR    7'h68
`define RTCD_REG_SEC     3'h0
`define RTCD_REG_MIN     3'h1
`define RTCD_REG_HOUR    3'h2
`define RTCD_REG_WDAY    3'h3
`define RTCD_REG_DATE    3'h4
`define RTCD_REG_MONTH   3'h5
`define RTCD_REG_YEAR    3'h6
`define RTCD_REG_CTRL    3'h7
`define RTCD_BIT_HALT    7
`define RTCD_BIT_FAIL    7
`define RTCD_BIT_CENT_EN 7
`define RTCD_BIT_CENT    6
`define RTCD_BIT_OUT     7
`define RTCD_MASK_SEC    8'h7F
`define RTCD_MASK_MIN    8'h7F
`define RTCD_MASK_HOUR   8'h3F
`define RTCD_MASK_WDAY   8'h07
`define RTCD_MASK_DATE   8'h3F
`define RTCD_MASK_MONTH  8'h1F
`define RTCD_MASK_YEAR   8'hFF
`define RTCD_RST_TIME    8'h00
`define RTCD_RST_DAY     8'h01
`define RTCD_CLK_MHZ     250
`define RTCD_FREEZE_MS   250
`define RTCD_OSC_TMO_US  100
`define RTCD_OSC_DIV     32768
`endif

// File: rtcd_pkg.sv
// Types shared by the clock/calendar block
package rtcd_pkg;
   typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK, S_TXLD}
      rtcd_state_t;
   typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} rtcd_phase_t;
endpackage : rtcd_pkg

// File: rtcd_bcd_step.sv
// One BCD counter field: next value and wrap from its upper limit
`timescale 1ns/10ps
module rtcd_bcd_step (
   input  wire logic [7:0] val,
   input  wire logic [7:0] lo,
   input  wire logic [7:0] hi,
   output logic      [7:0] nxt,
   output logic            wrap
);
   wire logic [3:0] tens_up = 4'(val[7:4] + 4'h1);
   wire logic [3:0] unit_up = 4'(val[3:0] + 4'h1);
   // Out-of-range values also wrap so a bad write cannot run away
   assign wrap = (val >= hi);
   assign nxt  = wrap ? lo :
                 (val[3:0] >= 4'h9) ? {tens_up, 4'h0} : {val[7:4], unit_up};
endmodule : rtcd_bcd_step

// File: rtcd_i2c_master.sv
// Behavioural I2C bus master that drives the clock's serial port
`timescale 1ns/10ps
module rtcd_i2c_master (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   int half = 8;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt;
      repeat (half) @(posedge clk);
      #1;
   endtask : wt
   // Data moves two cycles after the clock falls, never with it
   task automatic pulse(output logic b);
      wt();
      scl = 1'b1;
      wt();
      b = sda;
      scl = 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : pulse
   // Also a repeated START: data is released before the clock rises
   task automatic start;
      sda_low = 1'b0;
      wt();
      scl = 1'b1;
      wt();
      sda_low = 1'b1;
      wt();
      scl = 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : start
   task automatic stop;
      sda_low = 1'b1;
      wt();
      scl = 1'b1;
      wt();
      sda_low = 1'b0;
      wt();
   endtask : stop
   task automatic send(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         sda_low = ~d[i];
         pulse(b);
      end
      sda_low = 1'b0;
      pulse(b);
      ack = ~b;
   endtask : send
   task automatic recv(input logic ack, output logic [7:0] d);
      logic b;
      sda_low = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         pulse(b);
         d[i] = b;
      end
      sda_low = ack;
      pulse(b);
   endtask : recv
endmodule : rtcd_i2c_master

// File: tb_top.sv
// Self-checking bench for the BCD clock with its I2C port
`timescale 1ns/10ps
`include "rtcd_defs.svh"
module tb_top;
   logic        CLK, RST_B, osc, osc_free, ack;
   wire         scl, sda_low, sda;
   logic        SDA_OUT, SDA_OE, OSC_EN, OUT_OUT, OUT_OE;
   logic [31:0] seed, r;
   logic [7:0]  wb [8];
   logic [7:0]  rd [10];
   logic [2:0]  w;
   int          bad_count, num_checks, cycles;
   // Date, month, year before and after one midnight rollover
   logic [7:0]  cal [4][6] = '{'{8'h31, 8'h12, 8'h99, 8'h01, 8'h01, 8'h00},
                              '{8'h28, 8'h02, 8'h01, 8'h01, 8'h03, 8'h01},
                              '{8'h28, 8'h02, 8'h04, 8'h29, 8'h02, 8'h04},
                              '{8'h30, 8'h04, 8'h23, 8'h01, 8'h05, 8'h23}};
   assign sda = ~(sda_low | SDA_OE);
   rtcd_clock #(.FREEZE_CYC(4000), .OSC_TMO_CYC(200), .OSC_DIV(4)) dut (
      .CLK(CLK), .RST_B(RST_B), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .OSC_IN(osc), .OSC_EN(OSC_EN),
      .OUT_OUT(OUT_OUT), .OUT_OE(OUT_OE));
   rtcd_i2c_master m (.clk(CLK), .sda(sda), .scl(scl), .sda_low(sda_low));
   always #2 CLK = ~CLK;
   // Crystal stands still while the block holds it disabled
   always #62.5 if (osc_free) osc = OSC_EN & ~osc;
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         end_of_test();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [7:0] nwd(input logic [2:0] d);
      return (d == 3'h7) ? 8'h01 : {5'h00, d + 3'h1};
   endfunction : nwd
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [2:0] p, input int n);
      m.start();
      m.send({`RTCD_SLV_ADDR, 1'b0}, ack);
      check({7'h00, ack}, 8'h01);
      m.send({5'h00, p}, ack);
      check({7'h00, ack}, 8'h01);
      for (int i = 0; i < n; i++) begin
         m.send(wb[i], ack);
         check({7'h00, ack}, 8'h01);
      end
      m.stop();
   endtask : wr
   task automatic rdr(input logic setp, input logic [2:0] p, input int n);
      if (setp) begin
         m.start();
         m.send({`RTCD_SLV_ADDR, 1'b0}, ack);
         m.send({5'h00, p}, ack);
      end
      m.start();
      m.send({`RTCD_SLV_ADDR, 1'b1}, ack);
      check({7'h00, ack}, 8'h01);
      for (int i = 0; i < n; i++) begin
         m.recv(i < n - 1, rd[i]);
      end
      m.stop();
   endtask : rdr
   task automatic end_of_test;
      if (bad_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      CLK = 1'b0;
      RST_B = 1'b0;
      osc = 1'b0;
      osc_free = 1'b1;
      seed = 32'h0000D801;
      repeat (12) @(posedge CLK);
      #1;
      RST_B = 1'b1;
      repeat (8) @(posedge CLK);
      check({4'h0, SDA_OUT, OUT_OUT, OUT_OE, OSC_EN}, 8'h01);
      rdr(1'b0, 3'h0, 9);
      check(rd[0] & 8'h80, 8'h00);
      check(rd[1] & 8'h80, 8'h80);
      check(rd[7], 8'h80);
      check(rd[8], rd[0]);
      rdr(1'b0, 3'h0, 1);
      check({7'h00, rd[0] != rd[8]}, 8'h01);
      wb[0] = 8'h42;
      wb[1] = 8'h00;
      wr(3'h6, 2);
      check({7'h00, OUT_OE}, 8'h01);
      rdr(1'b1, 3'h6, 2);
      check(rd[0], 8'h42);
      check(rd[1], 8'h00);
      rdr(1'b0, 3'h0, 1);
      check(rd[0], 8'h00);
      wb[0] = 8'h80;
      wr(3'h7, 1);
      check({7'h00, OUT_OE}, 8'h00);
      for (int i = 0; i < 3; i++) begin
         r = rnd();
         m.start();
         m.send({r[6:0] ^ {6'h00, r[6:0] == `RTCD_SLV_ADDR}, 1'b0}, ack);
         check({7'h00, ack}, 8'h00);
         m.stop();
      end
      wb[0] = 8'h00;
      wr(3'h1, 1);
      rdr(1'b1, 3'h1, 1);
      check(rd[0] & 8'h80, 8'h00);
      m.half = 20;
      wb[0] = 8'h80;
      wr(3'h0, 1);
      check({7'h00, OSC_EN}, 8'h00);
      rdr(1'b1, 3'h1, 1);
      check(rd[0] & 8'h80, 8'h80);
      m.half = 8;
      osc_free = 1'b0;
      osc = 1'b0;
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         w = 3'(r[7:0] % 8'h07) + 3'h1;
         wb = '{8'hD9, 8'h59, {r[9:8], 6'h23}, {5'h00, w}, cal[k][0],
                cal[k][1], cal[k][2], 8'h80};
         wr(3'h0, 8);
         rdr(1'b1, 3'h0, 7);
         for (int i = 0; i < 7; i++) begin
            check(rd[i], wb[i] | {i == 1, 7'h00});
         end
         wb[0] = 8'h59;
         wr(3'h0, 1);
         // Four rising edges into a divider cleared while halted hold exactly one tick
         repeat (4) begin
            #62.5 osc = 1'b1;
            #62.5 osc = 1'b0;
         end
         rdr(1'b1, 3'h0, 7);
         check(rd[0], 8'h00);
         check(rd[1], 8'h80);
         check(rd[2], {r[9], r[8] ^ (r[9] & (k == 0)), 6'h00});
         check(rd[3], nwd(w));
         for (int i = 4; i < 7; i++) begin
            check(rd[i], cal[k][i - 1]);
         end
      end
      // Crystal loss alone, with the halt bit clear, must set the flag
      osc_free = 1'b1;
      wb[0] = 8'h00;
      wr(3'h1, 1);
      rdr(1'b1, 3'h1, 1);
      check(rd[0] & 8'h80, 8'h00);
      osc_free = 1'b0;
      repeat (300) @(posedge CLK);
      rdr(1'b1, 3'h1, 1);
      check(rd[0] & 8'h80, 8'h80);
      end_of_test();
   end
endmodule : tb_top
